/* bench/lsf_host_model.sv */
// host gpio pins and powered load facing the fault supervisor
`timescale 1ns/1ps
module lsf_host_model
  import lsf_pkg::*;
(
  input wire logic mclk, // system clock
  input wire logic on_cmd, // host wants switch on
  input wire logic sel_drv, // host drives select pin
  input wire logic sel_cmd, // select level when driven
  input wire lsf_pkg::lsf_sense_t flt, // load fault levels
  input wire logic sel_pd_en, // device pulldown on select
  input wire logic flag_out, // device fault drive value
  input wire logic flag_oe, // device fault drive enable
  output logic sw_on, // switch-enable pin
  output logic lim_sel, // limit-select pin
  output lsf_pkg::lsf_sense_t sense, // comparator levels
  output logic flag_in // resolved fault pin
);
  logic wander_ff = 1'b0;
  // a released pin with no pulldown must not look like a held level
  always_ff @(posedge mclk) begin
    wander_ff <= ~wander_ff;
  end
  assign sw_on = on_cmd;
  assign sense = flt;
  // gpio is strong enough to beat the select pulldown
  assign lim_sel = sel_drv ? sel_cmd :
    (sel_pd_en ? 1'b0 : wander_ff);
  assign flag_in = flag_oe ? flag_out : 1'b1; // external pull-up
endmodule : lsf_host_model

/* bench/test_lsf_top.sv */
// self-checking bench for the load switch fault supervisor
`timescale 1ns/1ps
`include "lsf_defs.svh"
module test_lsf_top;
  import lsf_pkg::*;
  localparam int BLANK = 20;
  localparam int RETRY = 60;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic on_cmd = 1'b0;
  logic sel_drv = 1'b0;
  logic sel_cmd = 1'b0;
  lsf_sense_t flt = '0;
  lsf_sense_t sense;
  logic sw_on, lim_sel, flag_in, sw_gate, lim_hi, sel_pd_en, flag_out;
  logic flag_oe, avs_waitrequest, irq;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int samples_checked = 0;
  int seed = 41;
  int len;

  always #2 mclk = ~mclk;

  lsf_top #(.AUTORETRY(1'b1), .BLANK_CYC(BLANK), .RETRY_CYC(RETRY)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .sw_on(sw_on), .lim_sel(lim_sel),
    .flag_in(flag_in), .sense(sense), .sw_gate(sw_gate), .lim_hi(lim_hi),
    .sel_pd_en(sel_pd_en), .flag_out(flag_out), .flag_oe(flag_oe),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));

  lsf_host_model host (
    .mclk(mclk), .on_cmd(on_cmd), .sel_drv(sel_drv), .sel_cmd(sel_cmd),
    .flt(flt), .sel_pd_en(sel_pd_en), .flag_out(flag_out),
    .flag_oe(flag_oe), .sw_on(sw_on), .lim_sel(lim_sel), .sense(sense),
    .flag_in(flag_in));

  // ----------------------------------------------------------
  // checking
  // ----------------------------------------------------------
  task automatic fail(input string what);
    bad_count++;
    $display("Error at %0t: %s", $time, what);
  endtask : fail

  task automatic chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail(what);
    end
  endtask : chk

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail($sformatf("read %h expected %h", got, exp));
    end
  endtask : cmp_word

  // read data is valid only at the edge that ends the access
  always @(posedge mclk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      cmp_word(avs_readdata, exp_q.pop_front());
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (5000) @(posedge mclk);
    fail("watchdog expired");
    conclude();
  end

  // ----------------------------------------------------------
  // bus and pin helpers
  // ----------------------------------------------------------
  task automatic bus(input logic wr, input logic [1:0] a,
                     input logic [31:0] d, input logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      fail("bus hang");
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next request is a fresh assignment
    @(posedge mclk);
  endtask : bus

  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask : wr

  function automatic logic pin(input int k);
    case (k)
      0: return sw_gate;
      1: return flag_oe;
      2: return lim_hi;
      default: return irq;
    endcase
  endfunction : pin

  task automatic wait_pin(input int k, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pin(k) !== v && n < lim);
    chk(pin(k), v, $sformatf("pin %0d late", k));
  endtask : wait_pin

  task automatic hold(input int n, input logic g, input logic f);
    repeat (n) begin
      @(posedge mclk);
      chk(sw_gate, g, "gate");
      chk(flag_oe, f, "fault pin");
      chk(flag_out, 1'b0, "fault drive");
    end
  endtask : hold

  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    @(posedge mclk);
    chk(sel_pd_en, 1'b1, "pulldown");
    chk(lim_hi, 1'b0, "limit");
    chk(sw_gate, 1'b0, "gate");
    chk(flag_oe, 1'b0, "fault pin");
    chk(flag_out, 1'b0, "fault drive");
    rd(`LSF_REG_MASK, 32'h0);
    rd(`LSF_REG_CTRL, 32'h1);
    rd(`LSF_REG_EVT, 32'h0);
    sel_drv <= 1'b1;
    sel_cmd <= 1'b1;
    wait_pin(2, 1'b1, 6);
    chk(sel_pd_en, 1'b0, "pulldown kept");
    sel_cmd <= 1'b0;
    wait_pin(2, 1'b0, 6);
    chk(sel_pd_en, 1'b0, "pulldown back");
    on_cmd <= 1'b1;
    wait_pin(0, 1'b1, 6);
    rd(`LSF_REG_STAT, 32'hc5);
    wr(`LSF_REG_MASK, ($random(seed) & 32'hfffffff8) | 32'h7);
    bus(1'b1, `LSF_REG_MASK, 32'h0, 4'he);
    rd(`LSF_REG_MASK, 32'h7);
    // short overcurrent bursts must never trip
    repeat (3) begin
      len = 1 + ({$random(seed)} % (BLANK - 3));
      flt.fwd <= 1'b1;
      repeat (len) @(posedge mclk);
      flt.fwd <= 1'b0;
      hold(BLANK + 5, 1'b1, 1'b0);
    end
    flt.fwd <= 1'b1;
    hold(BLANK, 1'b1, 1'b0);
    wait_pin(0, 1'b0, 10);
    chk(flag_oe, 1'b1, "no flag");
    wait_pin(3, 1'b1, 3);
    hold(RETRY - 10, 1'b0, 1'b1);
    wait_pin(0, 1'b1, 20);
    hold(BLANK - 2, 1'b1, 1'b1);
    wait_pin(0, 1'b0, 8);
    flt.fwd <= 1'b0;
    wait_pin(0, 1'b1, RETRY + 10);
    wait_pin(1, 1'b0, 6);
    hold(BLANK + 5, 1'b1, 1'b0);
    rd(`LSF_REG_EVT, 32'h5);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0, "irq stuck");
    wr(`LSF_REG_CTRL, 32'h0);
    flt.rev <= 1'b1;
    hold(BLANK, 1'b1, 1'b0);
    wait_pin(0, 1'b0, 10);
    chk(flag_oe, 1'b1, "no flag");
    flt.rev <= 1'b0;
    hold(RETRY + 20, 1'b0, 1'b1);
    on_cmd <= 1'b0;
    wait_pin(1, 1'b0, 6);
    chk(sw_gate, 1'b0, "gate");
    on_cmd <= 1'b1;
    wait_pin(0, 1'b1, 6);
    rd(`LSF_REG_EVT, 32'h1);
    wr(`LSF_REG_CTRL, 32'h1);
    wr(`LSF_REG_MASK, 32'h1);
    flt.hot <= 1'b1;
    wait_pin(0, 1'b0, 5);
    chk(flag_oe, 1'b1, "no flag");
    flt.hot <= 1'b0;
    hold(RETRY + 20, 1'b0, 1'b1);
    chk(irq, 1'b0, "masked irq");
    rd(`LSF_REG_EVT, 32'h2);
    sel_cmd <= 1'b1;
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    wait_pin(2, 1'b1, 5);
    chk(sel_pd_en, 1'b0, "pulldown");
    conclude();
  end
endmodule : test_lsf_top

/* hw/lsf_sync.sv */
// two flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module lsf_sync #(
  parameter int W = 1
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic [W-1:0] d, // asynchronous levels
  output logic [W-1:0] q // synchronised levels
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;
endmodule : lsf_sync

/* hw/lsf_timer.sv */
// interval counter that runs while enabled
`timescale 1ns/1ps
`include "lsf_defs.svh"
module lsf_timer #(
  parameter logic [`LSF_CNT_W-1:0] LIM = 1
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic en, // count while high, clear when low
  output logic done // high from the last cycle of the interval until en drops
);
  logic [`LSF_CNT_W-1:0] cnt_ff;

  // dropping en restarts the interval from zero
  always_ff @(posedge mclk) begin
    if (sys_rst || !en) begin
      cnt_ff <= '0;
    end else if (!done) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign done = en && (cnt_ff == LIM - 1'b1);
endmodule : lsf_timer

/* hw/lsf_top.sv */
// fault supervisor of a current-limited load switch
`timescale 1ns/1ps
`include "lsf_defs.svh"
module lsf_top
  import lsf_pkg::*;
#(
  parameter logic AUTORETRY = 1'b1,
  parameter logic [`LSF_CNT_W-1:0] BLANK_CYC =
    `LSF_BLANK_US * `LSF_CLK_MHZ,
  parameter logic [`LSF_CNT_W-1:0] RETRY_CYC =
    `LSF_RETRY_US * `LSF_CLK_MHZ
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic sys_rst, // power-on reset, sync
  input wire logic sw_on, // switch-enable pin
  input wire logic lim_sel, // limit-select pin
  input wire logic flag_in, // fault pin level
  input wire lsf_pkg::lsf_sense_t sense, // comparators
  output logic sw_gate, // pass switch closed
  output logic lim_hi, // 500mA threshold chosen
  output logic sel_pd_en, // select pulldown applied
  output logic flag_out, // fault pin drive level
  output logic flag_oe, // fault pin pulled low
  input wire logic [1:0] avs_address, // word index
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  output logic irq // level interrupt
);
  import lsf_pkg::*;

  // ----------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------
  logic [5:0] pins_s;
  logic on_s;
  logic sel_s;
  logic flag_s;
  lsf_sense_t sense_s;

  lsf_sync #(.W(6)) u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .d({sw_on, lim_sel, flag_in, sense}),
    .q(pins_s)
  );

  assign on_s = pins_s[5];
  assign sel_s = pins_s[4];
  assign flag_s = pins_s[3];
  assign sense_s = pins_s[2:0];

  logic oc_s;
  assign oc_s = sense_s.fwd | sense_s.rev;

  // ----------------------------------------------------------
  // limit selection
  // ----------------------------------------------------------
  logic sel_d_ff;
  logic sel_rise;
  logic pd_ff;
  logic lim_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_d_ff <= 1'b0;
    end else begin
      sel_d_ff <= sel_s;
    end
  end

  // synchroniser clears at reset, so a select pin that rose
  // with the supply also shows up here as a rising edge
  assign sel_rise = sel_s && !sel_d_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pd_ff <= 1'b1;
    end else if (sel_rise) begin
      pd_ff <= 1'b0;
    end
  end

  // while the pulldown holds, the pin can only read low;
  // the host must overpower it for the first rise
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      lim_ff <= 1'b0;
    end else if (sel_rise || !pd_ff) begin
      lim_ff <= sel_s;
    end
  end

  // ----------------------------------------------------------
  // control registers
  // ----------------------------------------------------------
  logic retry_mode_ff;
  logic [`LSF_EVT_W-1:0] mask_ff;
  logic [`LSF_EVT_W-1:0] evt_ff;
  logic acc;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_evt;

  assign acc = (avs_read || avs_write) && !avs_waitrequest;
  assign wr_ctrl = acc && avs_write && avs_byteenable[0] &&
    (avs_address == `LSF_REG_CTRL);
  assign wr_mask = acc && avs_write && avs_byteenable[0] &&
    (avs_address == `LSF_REG_MASK);
  assign rd_evt = acc && avs_read &&
    (avs_address == `LSF_REG_EVT);

  // variant comes from the build, software may override it
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      retry_mode_ff <= AUTORETRY;
    end else if (wr_ctrl) begin
      retry_mode_ff <= avs_writedata[`LSF_CTRL_RETRY];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_ff <= `LSF_MASK_RST;
    end else if (wr_mask) begin
      mask_ff <= avs_writedata[`LSF_EVT_W-1:0];
    end
  end

  // ----------------------------------------------------------
  // interval timers
  // ----------------------------------------------------------
  lsf_state_t st_ff;
  lsf_state_t nxt_st;
  logic blank_en;
  logic blank_done;
  logic retry_done;

  // blanking runs only while closed and in limit
  assign blank_en = (st_ff == lsf_run) && oc_s && on_s;

  lsf_timer #(.LIM(BLANK_CYC)) u_blank (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .en(blank_en),
    .done(blank_done)
  );

  lsf_timer #(.LIM(RETRY_CYC)) u_retry (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .en(st_ff == lsf_retry),
    .done(retry_done)
  );

  // ----------------------------------------------------------
  // switch state machine
  // ----------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      lsf_off: begin
        if (on_s) begin
          nxt_st = lsf_run;
        end
      end
      lsf_run: begin
        if (sense_s.hot) begin
          nxt_st = lsf_latch;
        end else if (blank_done) begin
          nxt_st = retry_mode_ff ? lsf_retry : lsf_latch;
        end
      end
      lsf_retry: begin
        if (sense_s.hot) begin
          nxt_st = lsf_latch;
        end else if (retry_done) begin
          nxt_st = lsf_run;
        end
      end
      lsf_latch: begin
        nxt_st = lsf_latch;
      end
      default: begin
        nxt_st = lsf_off;
      end
    endcase
    if (!on_s) begin
      nxt_st = lsf_off;
    end
  end

  // cyc_ff keeps the flag low across a reclosed blanking
  // window while the overcurrent is still there
  logic cyc_ff;
  logic nxt_cyc;
  logic nxt_flag;

  always_comb begin
    nxt_cyc = cyc_ff;
    if (nxt_st == lsf_retry) begin
      nxt_cyc = 1'b1;
    end else if (nxt_st != lsf_run || !oc_s) begin
      nxt_cyc = 1'b0;
    end
  end

  assign nxt_flag = (nxt_st == lsf_retry) ||
    (nxt_st == lsf_latch) || (nxt_st == lsf_run && nxt_cyc);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_ff <= lsf_off;
      cyc_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      cyc_ff <= nxt_cyc;
    end
  end

  // ----------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------
  logic gate_ff;
  logic flag_oe_ff;
  logic flag_out_ff;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gate_ff <= 1'b0;
      flag_oe_ff <= 1'b0;
      flag_out_ff <= 1'b0;
    end else begin
      gate_ff <= (nxt_st == lsf_run);
      flag_oe_ff <= nxt_flag;
      flag_out_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------
  logic [`LSF_EVT_W-1:0] evt_set;
  logic irq_ff;

  assign evt_set[`LSF_EVT_OC] = (st_ff == lsf_run) &&
    blank_done && !sense_s.hot;
  assign evt_set[`LSF_EVT_HOT] = (st_ff != lsf_latch) &&
    (st_ff != lsf_off) && sense_s.hot && on_s;
  assign evt_set[`LSF_EVT_RETRY] = (st_ff == lsf_retry) &&
    retry_done && on_s && !sense_s.hot;

  // read data is captured a cycle before the read completes, so
  // only bits already shown to software are cleared; an event
  // landing in the wait cycle or the clearing cycle survives
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      evt_ff <= '0;
    end else begin
      evt_ff <= (evt_ff & ~(rd_evt ? rdata_ff[`LSF_EVT_W-1:0] : '0)) |
        evt_set;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(evt_ff & mask_ff);
    end
  end

  // ----------------------------------------------------------
  // avalon slave, one wait cycle per access
  // ----------------------------------------------------------
  logic wait_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [`LSF_STAT_W-1:0] stat;

  assign stat = {flag_s, on_s, pd_ff, lim_ff,
    flag_oe_ff, gate_ff, st_ff};

  always_comb begin
    nxt_rdata = '0;
    case (avs_address)
      `LSF_REG_CTRL: nxt_rdata[`LSF_CTRL_RETRY] = retry_mode_ff;
      `LSF_REG_STAT: nxt_rdata[`LSF_STAT_W-1:0] = stat;
      `LSF_REG_EVT: nxt_rdata[`LSF_EVT_W-1:0] = evt_ff;
      `LSF_REG_MASK: nxt_rdata[`LSF_EVT_W-1:0] = mask_ff;
      default: nxt_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wait_ff <= 1'b1;
      rdata_ff <= '0;
    end else if (wait_ff && (avs_read || avs_write)) begin
      wait_ff <= 1'b0;
      rdata_ff <= avs_read ? nxt_rdata : '0;
    end else begin
      wait_ff <= 1'b1;
    end
  end

  assign sw_gate = gate_ff;
  assign lim_hi = lim_ff;
  assign sel_pd_en = pd_ff;
  assign flag_out = flag_out_ff;
  assign flag_oe = flag_oe_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = wait_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------
  // checks
  // ----------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  on_low_off_a: assert property (
    !on_s |=> !sw_gate && !flag_oe)
    else $error("switch or flag active with enable low");

  hot_latch_a: assert property (
    on_s && sense_s.hot && st_ff == lsf_run
      |=> st_ff == lsf_latch && flag_oe && !sw_gate)
    else $error("thermal fault not acted on at once");

  blank_trip_a: assert property (
    blank_en && blank_done && !sense_s.hot
      |=> !sw_gate && flag_oe)
    else $error("blanking expiry did not open switch");

  clear_flag_a: assert property (
    st_ff == lsf_run && on_s && !oc_s && !sense_s.hot
      |=> !flag_oe && sw_gate)
    else $error("flag held without overcurrent");

  latch_hold_a: assert property (
    st_ff == lsf_latch && on_s |=> !sw_gate && flag_oe)
    else $error("latched switch released while enabled");

  retry_close_a: assert property (
    st_ff == lsf_retry && retry_done && on_s && !sense_s.hot
      |=> sw_gate && flag_oe == $past(oc_s) && cyc_ff == $past(oc_s))
    else $error("retry expiry did not reclose switch");

  retry_hold_a: assert property (
    $rose(st_ff == lsf_retry) |-> !sw_gate && flag_oe)
    else $error("retry wait without open switch and flag");

  sel_rise_a: assert property (
    sel_rise |=> lim_hi && !sel_pd_en)
    else $error("select rise did not pick high limit");

  sel_follow_a: assert property (
    !sel_pd_en ##1 !sel_pd_en |-> lim_hi == $past(sel_s))
    else $error("limit does not follow select pin");

  irq_level_a: assert property (
    |(evt_ff & mask_ff) |=> irq)
    else $error("unmasked event without interrupt");

  bus_ack_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("wait request low for more than a cycle");
endmodule : lsf_top

/* pkg/lsf_defs.svh */
// constants for the load switch fault supervisor
`ifndef LSF_DEFS_SVH
`define LSF_DEFS_SVH

// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define LSF_CLK_MHZ 250
`define LSF_BLANK_US 37000
`define LSF_RETRY_US 555000
`define LSF_CNT_W 32

// ----------------------------------------------------------
// register word indexes, byte address is four times these
// ----------------------------------------------------------
`define LSF_REG_CTRL 2'h0
`define LSF_REG_STAT 2'h1
`define LSF_REG_EVT 2'h2
`define LSF_REG_MASK 2'h3

// ----------------------------------------------------------
// fields
// ----------------------------------------------------------
`define LSF_CTRL_RETRY 0
`define LSF_EVT_OC 0
`define LSF_EVT_HOT 1
`define LSF_EVT_RETRY 2
`define LSF_EVT_W 3
`define LSF_MASK_RST 3'h0
`define LSF_STAT_W 8

`endif

/* pkg/lsf_pkg.sv */
// types shared by the load switch fault supervisor
package lsf_pkg;

  typedef enum logic [1:0] {
    lsf_off,
    lsf_run,
    lsf_retry,
    lsf_latch
  } lsf_state_t;

  // raw comparator results from the analog front end
  typedef struct packed {
    logic fwd;
    logic rev;
    logic hot;
  } lsf_sense_t;

endpackage : lsf_pkg
